// File: include/interval_timer_pkg.sv
// constants and carrier types for the dual 8-bit interval timer
// assumes one 10 MHz clock where one clock is one instruction cycle
package interval_timer_pkg;
	// ****************************************************************
	// register indices and byte addresses (byte address = index * 4)
	// ****************************************************************
	localparam logic [7:0] IDX_TWO_CTRL = 8'h18; // timer_two_control
	localparam logic [7:0] IDX_ONE_CTRL = 8'h19; // timer_one_control
	localparam logic [7:0] IDX_TWO_DATA = 8'h1A; // timer_two_interval_data
	localparam logic [7:0] IDX_ONE_DATA = 8'h1B; // timer_one_interval_data
	localparam int ADDR_W = 8;
	// ****************************************************************
	// control register field positions
	// ****************************************************************
	localparam int F_FLAG = 7; // interval flag
	localparam int F_IE = 6; // irq enable
	localparam int F_OS = 4; // wave set field, two bits from here
	localparam int F_CS = 2; // clock select field, two bits from here
	localparam int F_STP = 1; // suspend bit
	localparam int F_STR = 0; // run bit
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] CNT_CLEAR = 8'h00;
	// ****************************************************************
	// clock select and wave set encodings
	// ****************************************************************
	localparam logic [1:0] CS_FAST = 2'h0;
	localparam logic [1:0] CS_MID = 2'h1;
	localparam logic [1:0] CS_SLOW = 2'h2;
	localparam logic [1:0] CS_SPECIAL = 2'h3; // external or cascade
	localparam logic [1:0] OS_PORT = 2'h0;
	localparam logic [1:0] OS_LOW = 2'h1;
	localparam logic [1:0] OS_HIGH = 2'h2;
	localparam logic [1:0] OS_APPLY = 2'h3;
	// ****************************************************************
	// count periods in instruction cycles (one clock each)
	// ****************************************************************
	localparam int PER_FAST = 2;
	localparam int PER_MID = 32;
	localparam int PER_SLOW = 512;
	localparam int SH_FAST = $clog2(PER_FAST);
	localparam int SH_MID = $clog2(PER_MID);
	localparam int SH_SLOW = $clog2(PER_SLOW);
	localparam int PRE_W = SH_SLOW;
	// ****************************************************************
	// bus responses
	// ****************************************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************************************
	// axi4-lite carriers
	// ****************************************************************
	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_rsp_t;
endpackage : interval_timer_pkg

// File: hdl/interval_timer.sv
// dual 8-bit interval timer, cascadable to 16 bits, axi4-lite slave
// assumes a master that keeps axi4-lite rules; pin inputs are async
// Operation
// - each timer counts one of three prescaled clocks
// - run bit rising clears counter, loads latch
// - match sets flag, clears counter, reloads latch
// - irq when flag set and enable set
// - match interval is period times n plus one
// - data write stores compare, read gives count
// - wave preset only while timer stopped
// - preset 01 or 10 only loads level latch
// - preset 11 while stopped drives latched level
// - timer one counts external pin on code 11
// - clearing run after suspend adds no count
// - timer two select 11 means cascade mode
// - cascade: two is high byte, one controls
// - cascade match sets timer one flag, irq
// - run bit 0 to 1 clears and starts
// - suspend holds count; 11 to 01 resumes
// - codes 00 and 10 stop; to 01 clears
// - timer two has same run and suspend
// - select 00/01/10 gives 2/32/512 cycles
// - flag clears on 0 write; rmw read 1
// - wave field: port, low, high, apply
module interval_timer
	import interval_timer_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// register bus
	input wire axi_req_t bus_req_i,
	input wire logic rmw_read_i,
	output axi_rsp_t bus_rsp_o,
	// pins
	input wire logic external_count_clock_in_i,
	output logic square_wave_pin_o,
	output logic square_wave_pin_oe_n_o,
	output logic irq_o
);
	// ****************************************************************
	// helpers
	// ****************************************************************
	// tick of the selected prescaled clock
	function automatic logic src_tick(input logic [1:0] cs,
		input logic [PRE_W-1:0] pre, input logic ext);
		case (cs)
			CS_FAST: src_tick = &pre[SH_FAST-1:0];
			CS_MID: src_tick = &pre[SH_MID-1:0];
			CS_SLOW: src_tick = &pre[SH_SLOW-1:0];
			default: src_tick = ext;
		endcase
	endfunction : src_tick
	// word address to register index match
	function automatic logic hits(input logic [ADDR_W-1:0] a,
		input logic [7:0] idx);
		hits = (a[ADDR_W-1:2] == idx[ADDR_W-3:0]);
	endfunction : hits

	// ****************************************************************
	// state
	// ****************************************************************
	logic [PRE_W-1:0] pre_q; // free prescaler
	logic ext_s1_q, ext_s2_q, ext_s3_q; // pin synchroniser
	logic ext_lvl_q; // accepted pin level
	logic ext_tick_q; // one pulse per accepted rise
	logic [7:0] data_q [2]; // compare values written
	logic [7:0] latch_q [2]; // compare latches
	logic [7:0] cnt_q [2]; // counters
	logic [1:0] flag_q, ie_q, str_q, stp_q;
	logic [1:0] os_q [2]; // wave set fields
	logic [1:0] cs_q [2]; // clock selects
	logic lvl_q; // preset level latch
	logic wave_q; // square wave state
	logic irq_q;
	// bus state
	logic aw_q, w_q, bv_q, ar_q, rv_q;
	logic [ADDR_W-1:0] awa_q;
	logic [31:0] wd_q, rd_q;
	logic [3:0] ws_q;
	logic [1:0] bresp_q, rresp_q;

	// ****************************************************************
	// combinational decode
	// ****************************************************************
	logic wr; // write performed this cycle
	logic [1:0] wr_ctrl, wr_data;
	logic [7:0] wbyte;
	logic casc; // cascade mode
	logic [1:0] tick, run, start, match, hit;
	logic [15:0] cnt16, cmp16;
	assign wr = aw_q & w_q & ~bv_q & ws_q[0];
	assign wbyte = wd_q[7:0];
	assign wr_ctrl[0] = wr & hits(awa_q, IDX_ONE_CTRL);
	assign wr_ctrl[1] = wr & hits(awa_q, IDX_TWO_CTRL);
	assign wr_data[0] = wr & hits(awa_q, IDX_ONE_DATA);
	assign wr_data[1] = wr & hits(awa_q, IDX_TWO_DATA);
	assign casc = (cs_q[1] == CS_SPECIAL);
	assign cnt16 = {cnt_q[1], cnt_q[0]};
	assign cmp16 = {latch_q[1], latch_q[0]};

	// per timer tick, run, start and match
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_tm
			// timer two has no external pin: code 11 is cascade
			assign tick[g] = src_tick(cs_q[g], pre_q,
				(g == 0) ? ext_tick_q : 1'b0);
			// running only with run 1 and suspend 0; no stop count
			assign run[g] = str_q[g] & ~stp_q[g];
			// clear only on a 0 to 1 edge of the run bit
			assign start[g] = wr_ctrl[g] & wbyte[F_STR]
				& ~str_q[g];
		end
	endgenerate
	assign match[0] = casc ? (cnt16 == cmp16)
		: (cnt_q[0] == latch_q[0]);
	assign match[1] = (cnt_q[1] == latch_q[1]);
	assign hit[0] = tick[0] & run[0] & match[0] & ~start[0];
	assign hit[1] = tick[1] & run[1] & match[1] & ~start[1] & ~casc;

	// ****************************************************************
	// prescaler and external clock
	// ****************************************************************
	// free running divider of the instruction clock
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + 1'b1;
		end
	end
	// three flop synchroniser, rise accepted when stages 2 and 3 agree
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
			ext_lvl_q <= 1'b0;
			ext_tick_q <= 1'b0;
		end else begin
			ext_s1_q <= external_count_clock_in_i;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			if (ext_s2_q == ext_s3_q) begin
				ext_lvl_q <= ext_s3_q;
			end
			ext_tick_q <= (ext_s2_q == ext_s3_q) & ext_s3_q
				& ~ext_lvl_q;
		end
	end

	// ****************************************************************
	// control and data registers
	// ****************************************************************
	// control bits per timer; flag set beats software clear
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 2; i++) begin
				flag_q[i] <= CTRL_RESET[F_FLAG];
				ie_q[i] <= CTRL_RESET[F_IE];
				os_q[i] <= CTRL_RESET[F_OS+:2];
				cs_q[i] <= CTRL_RESET[F_CS+:2];
				stp_q[i] <= CTRL_RESET[F_STP];
				str_q[i] <= CTRL_RESET[F_STR];
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_ctrl[i]) begin
					ie_q[i] <= wbyte[F_IE];
					// timer two field is kept but drives nothing
					os_q[i] <= wbyte[F_OS+:2];
					cs_q[i] <= wbyte[F_CS+:2];
					stp_q[i] <= wbyte[F_STP];
					str_q[i] <= wbyte[F_STR];
				end
				// a match sets the flag; writing 1 changes nothing
				if (hit[i]) begin
					flag_q[i] <= 1'b1;
				end else if (wr_ctrl[i] && !wbyte[F_FLAG]) begin
					flag_q[i] <= 1'b0;
				end
			end
		end
	end
	// compare values as written by software
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_q[0] <= DATA_RESET;
			data_q[1] <= DATA_RESET;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_data[i]) begin
					data_q[i] <= wbyte;
				end
			end
		end
	end

	// ****************************************************************
	// counters and compare latches
	// ****************************************************************
	// timer one counter, low byte in cascade
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q[0] <= CNT_CLEAR;
			latch_q[0] <= DATA_RESET;
		end else if (start[0]) begin
			cnt_q[0] <= CNT_CLEAR;
			latch_q[0] <= data_q[0];
		end else if (tick[0] && run[0]) begin
			// n+1 ticks per match: 0..n then back to 0
			cnt_q[0] <= match[0] ? CNT_CLEAR
				: cnt_q[0] + 8'h01;
			if (match[0]) begin
				latch_q[0] <= data_q[0];
			end
		end
	end
	// timer two counter, high byte under timer one control in cascade
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q[1] <= CNT_CLEAR;
			latch_q[1] <= DATA_RESET;
		end else if (casc) begin
			if (start[0]) begin
				cnt_q[1] <= CNT_CLEAR;
				latch_q[1] <= data_q[1];
			end else if (tick[0] && run[0]) begin
				if (match[0]) begin
					cnt_q[1] <= CNT_CLEAR;
					latch_q[1] <= data_q[1];
				end else if (&cnt_q[0]) begin
					cnt_q[1] <= cnt_q[1] + 8'h01;
				end
			end
		end else if (start[1]) begin
			cnt_q[1] <= CNT_CLEAR;
			latch_q[1] <= data_q[1];
		end else if (tick[1] && run[1]) begin
			cnt_q[1] <= match[1] ? CNT_CLEAR : cnt_q[1] + 8'h01;
			if (match[1]) begin
				latch_q[1] <= data_q[1];
			end
		end
	end

	// ****************************************************************
	// square wave output and interrupt
	// ****************************************************************
	// level latch, apply while stopped, toggle on timer one match
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lvl_q <= 1'b0;
			wave_q <= 1'b0;
		end else begin
			if (wr_ctrl[0] && wbyte[F_OS+:2] == OS_LOW) begin
				lvl_q <= 1'b0;
			end else if (wr_ctrl[0] && wbyte[F_OS+:2] == OS_HIGH) begin
				lvl_q <= 1'b1;
			end
			// preset is ignored while the timer runs
			if (wr_ctrl[0] && wbyte[F_OS+:2] == OS_APPLY
				&& !str_q[0]) begin
				wave_q <= lvl_q;
			end else if (hit[0]) begin
				wave_q <= ~wave_q;
			end
		end
	end
	// pin enable is low while the wave drives the pin
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			square_wave_pin_o <= 1'b0;
			square_wave_pin_oe_n_o <= 1'b1;
			irq_q <= 1'b0;
		end else begin
			square_wave_pin_o <= wave_q;
			square_wave_pin_oe_n_o <= (os_q[0] == OS_PORT);
			irq_q <= |(flag_q & ie_q);
		end
	end
	assign irq_o = irq_q;

	// ****************************************************************
	// axi4-lite slave
	// ****************************************************************
	// write: address and data taken in either order, then response
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			bv_q <= 1'b0;
			awa_q <= '0;
			wd_q <= '0;
			ws_q <= '0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (bus_req_i.awvalid && !aw_q) begin
				aw_q <= 1'b1;
				awa_q <= bus_req_i.awaddr;
			end
			if (bus_req_i.wvalid && !w_q) begin
				w_q <= 1'b1;
				wd_q <= bus_req_i.wdata;
				ws_q <= bus_req_i.wstrb;
			end
			if (aw_q && w_q && !bv_q) begin
				bv_q <= 1'b1;
				bresp_q <= RESP_SLVERR;
				if (hits(awa_q, IDX_ONE_CTRL) || hits(awa_q, IDX_TWO_CTRL)
					|| hits(awa_q, IDX_ONE_DATA)
					|| hits(awa_q, IDX_TWO_DATA)) begin
					bresp_q <= RESP_OKAY;
				end
			end
			if (bv_q && bus_req_i.bready) begin
				bv_q <= 1'b0;
				aw_q <= 1'b0;
				w_q <= 1'b0;
			end
		end
	end
	// read: data register returns the live counter
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ar_q <= 1'b0;
			rv_q <= 1'b0;
			rd_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (bus_req_i.arvalid && !ar_q && !rv_q) begin
			ar_q <= 1'b1;
			rv_q <= 1'b1;
			rresp_q <= RESP_OKAY;
			rd_q <= '0;
			if (hits(bus_req_i.araddr, IDX_ONE_CTRL)) begin
				rd_q[7:0] <= {flag_q[0] | rmw_read_i, ie_q[0], os_q[0],
					cs_q[0], stp_q[0], str_q[0]};
			end else if (hits(bus_req_i.araddr, IDX_TWO_CTRL)) begin
				rd_q[7:0] <= {flag_q[1] | rmw_read_i, ie_q[1], os_q[1],
					cs_q[1], stp_q[1], str_q[1]};
			end else if (hits(bus_req_i.araddr, IDX_ONE_DATA)) begin
				rd_q[7:0] <= cnt_q[0];
			end else if (hits(bus_req_i.araddr, IDX_TWO_DATA)) begin
				rd_q[7:0] <= cnt_q[1];
			end else begin
				rresp_q <= RESP_SLVERR;
			end
		end else if (rv_q && bus_req_i.rready) begin
			rv_q <= 1'b0;
			ar_q <= 1'b0;
		end
	end
	// answers straight from flops
	assign bus_rsp_o.awready = ~aw_q;
	assign bus_rsp_o.wready = ~w_q;
	assign bus_rsp_o.bvalid = bv_q;
	assign bus_rsp_o.bresp = bresp_q;
	assign bus_rsp_o.arready = ~ar_q & ~rv_q;
	assign bus_rsp_o.rvalid = rv_q;
	assign bus_rsp_o.rdata = rd_q;
	assign bus_rsp_o.rresp = rresp_q;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_apply;
		wr_ctrl[0] && wbyte[F_OS+:2] == OS_APPLY && !str_q[0];
	endsequence
	a_start_clears: assert property (start[0] |=>
		cnt_q[0] == CNT_CLEAR && latch_q[0] == $past(data_q[0]))
		else $error("start did not clear counter");
	a_match_flag: assert property (hit[0] |=> flag_q[0]
		&& cnt_q[0] == CNT_CLEAR)
		else $error("match did not set flag");
	a_irq_follows: assert property ((flag_q & ie_q) != 2'h0
		|=> irq_o)
		else $error("irq missing");
	a_suspend_holds: assert property ((str_q[0] && stp_q[0]
		&& !casc && !wr_ctrl[0]) [*2] |-> $stable(cnt_q[0]))
		else $error("suspended counter moved");
	a_preset_apply: assert property (s_apply
		|=> wave_q == $past(lvl_q))
		else $error("preset level not applied");
	a_preset_latch: assert property (wr_ctrl[0] && !hit[0]
		&& (wbyte[F_OS+:2] == OS_LOW || wbyte[F_OS+:2] == OS_HIGH)
		|=> $stable(wave_q))
		else $error("latch write moved pin");
	a_flag_clear: assert property (wr_ctrl[0] && !wbyte[F_FLAG]
		&& !hit[0] |=> !flag_q[0])
		else $error("flag not cleared");
	a_fast_tick: assert property (cs_q[0] == CS_FAST && tick[0]
		&& !wr_ctrl[0] ##1 !wr_ctrl[0] |-> !tick[0] ##1 tick[0])
		else $error("fast clock period wrong");
endmodule : interval_timer

// File: sim/ext_count_source.sv
// model of the count clock source facing the timer's external pin
// assumes the bench calls send_pulses from its main sequence
module ext_count_source (
	// clock
	input wire logic clk_i,
	// count clock toward the timer
	output logic ext_clk_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// the line stands low between bursts
	initial ext_clk_o = 1'b0;
	// k rising edges; each level held four clocks for the synchroniser
	task automatic send_pulses(input int k);
		int i;
		for (i = 0; i < k; i++) begin
			repeat (4) @(posedge clk_i);
			ext_clk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			ext_clk_o <= 1'b0;
		end
		// let the last edge reach the counter
		repeat (6) @(posedge clk_i);
	endtask : send_pulses
endmodule : ext_count_source

// File: sim/tb.sv
// self-checking bench for the dual interval timer
// assumes the package constants and a 10 MHz clock
module tb
	import interval_timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// *****
	// signals
	// *****
	localparam logic [7:0] A_C2 = {IDX_TWO_CTRL[5:0], 2'h0};
	localparam logic [7:0] A_C1 = {IDX_ONE_CTRL[5:0], 2'h0};
	localparam logic [7:0] A_D2 = {IDX_TWO_DATA[5:0], 2'h0};
	localparam logic [7:0] A_D1 = {IDX_ONE_DATA[5:0], 2'h0};
	logic clk_i; // bench clock
	logic rst_n_i; // reset, active low
	axi_req_t req; // master side of the bus
	axi_rsp_t rsp; // slave answers
	logic rmw_q; // read belongs to a read-modify-write
	logic ext_clk; // count clock from the source model
	logic pin; // square wave level
	logic pin_oe_n; // low while the block drives the pin
	logic irq_o; // interrupt request
	logic [33:0] exp_q[$]; // noted read answers: resp and data
	logic [16:0] rnd; // random state
	logic [7:0] n; // random compare value
	int cyc = 0; // free cycle count
	int fail_count; // mismatches
	int checks_done; // comparisons made
	int i; // loop index
	int per[3] = '{PER_FAST, PER_MID, PER_SLOW}; // cycles per tick per code
	logic [7:0] nv[3] = '{8'h14, 8'h03, 8'h01}; // compare per code
	interval_timer u_dut (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.bus_req_i(req),
		.rmw_read_i(rmw_q),
		.bus_rsp_o(rsp),
		.external_count_clock_in_i(ext_clk),
		.square_wave_pin_o(pin),
		.square_wave_pin_oe_n_o(pin_oe_n),
		.irq_o(irq_o)
	);
	ext_count_source u_src (
		.clk_i(clk_i),
		.ext_clk_o(ext_clk)
	);
	// clock and cycle count
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i) cyc <= cyc + 1;
	// *****
	// helpers
	// *****
	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction : lfsr
	// one comparison, counted; a miss is reported at once
	task automatic check(input logic [33:0] got, input logic [33:0] e);
		checks_done++;
		if (got !== e) begin
			fail_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, e);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// one write; address and data offered together, each freed when taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw_hit;
		logic w_hit;
		logic b_hit;
		int t;
		@(posedge clk_i);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= {24'h0, d};
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		for (t = 0; t < 50; t++) begin
			@(negedge clk_i);
			aw_hit = req.awvalid & rsp.awready;
			w_hit = req.wvalid & rsp.wready;
			b_hit = rsp.bvalid;
			@(posedge clk_i);
			if (aw_hit) req.awvalid <= 1'b0;
			if (w_hit) req.wvalid <= 1'b0;
			if (b_hit) break;
		end
		req.bready <= 1'b0;
		if (t == 50) fail_count++;
	endtask : wr
	// one read; the expected answer is noted for the monitor
	task automatic rd(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] r, input logic m);
		logic ar_hit;
		logic r_hit;
		int t;
		exp_q.push_back({r, 24'h0, d});
		@(posedge clk_i);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		rmw_q <= m;
		for (t = 0; t < 50; t++) begin
			@(negedge clk_i);
			ar_hit = req.arvalid & rsp.arready;
			r_hit = rsp.rvalid;
			@(posedge clk_i);
			if (ar_hit) req.arvalid <= 1'b0;
			if (r_hit) break;
		end
		req.rready <= 1'b0;
		rmw_q <= 1'b0;
		if (t == 50) fail_count++;
	endtask : rd
	// read answer monitor: oldest note against what the slave returns
	always @(negedge clk_i) begin
		if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
			check({rsp.rresp, rsp.rdata},
				exp_q.size() > 0 ? exp_q.pop_front() : 'x);
		end
	end
	// settled level of pin (0), pin enable (1) or interrupt (2)
	task automatic out_is(input int w, input logic e);
		@(negedge clk_i);
		check({33'h0, w == 0 ? pin : w == 1 ? pin_oe_n : irq_o}, {33'h0, e});
	endtask : out_is
	// cycle count of the next interrupt request
	task automatic wait_irq(output int t);
		int k;
		for (k = 0; k < 3000; k++) begin
			@(negedge clk_i);
			if (irq_o === 1'b1) break;
		end
		if (k == 3000) fail_count++;
		t = cyc;
	endtask : wait_irq
	// spacing of two matches with the flag cleared between them
	task automatic interval(input logic [7:0] a, input logic [7:0] c,
		input int e);
		int t1;
		int t2;
		wait_irq(t1);
		wr(a, c);
		wait_irq(t2);
		check(34'(t2 - t1), 34'(e));
	endtask : interval
	// watchdog: a hang counts as a miss
	initial begin
		repeat (40000) @(posedge clk_i);
		fail_count++;
		tally_and_finish();
	end
	// *****
	// tests
	// *****
	initial begin
		req = '0;
		rmw_q = 1'b0;
		rst_n_i = 1'b0;
		fail_count = 0;
		checks_done = 0;
		rnd = 17'h15BE9;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// reset values, then an unmapped place
		for (i = 0; i < 4; i++) rd(A_C2 + 8'(4 * i), 8'h00, RESP_OKAY, 1'b0);
		rd(8'h00, 8'h00, RESP_SLVERR, 1'b0);
		out_is(1, 1'b1);
		$display("test reset done");
		// square wave preset while stopped, then refused while running
		wr(A_C1, 8'h2C);
		out_is(0, 1'b0);
		out_is(1, 1'b0);
		wr(A_C1, 8'h3C);
		out_is(0, 1'b1);
		wr(A_C1, 8'h1C);
		out_is(0, 1'b1);
		wr(A_C1, 8'h3C);
		out_is(0, 1'b0);
		wr(A_C1, 8'h2D);
		wr(A_C1, 8'h3D);
		out_is(0, 1'b0);
		wr(A_C1, 8'h00);
		$display("test wave done");
		// timer two on each internal clock
		for (i = 0; i < 3; i++) begin
			wr(A_D2, nv[i]);
			wr(A_C2, 8'h41 | 8'(4 * i));
			interval(A_C2, 8'h41 | 8'(4 * i), (nv[i] + 1) * per[i]);
			wr(A_C2, 8'h00);
		end
		$display("test internal done");
		// cascade: upper byte from timer two, run by timer one
		wr(A_C2, {4'h0, CS_SPECIAL, 2'h0});
		wr(A_D2, 8'h01);
		wr(A_D1, 8'h02);
		wr(A_C1, 8'h41);
		interval(A_C1, 8'h41, 259 * PER_FAST);
		wr(A_C1, 8'h00);
		// cascade on the pin clock, each byte read twice to agree
		wr(A_C1, 8'h0D);
		u_src.send_pulses(3);
		for (i = 0; i < 2; i++) rd(A_D1, 8'h03, RESP_OKAY, 1'b0);
		for (i = 0; i < 2; i++) rd(A_D2, 8'h00, RESP_OKAY, 1'b0);
		wr(A_C1, 8'h00);
		wr(A_C2, 8'h00);
		$display("test cascade done");
		// external clock: start, suspend, resume, stop codes
		wr(A_D1, 8'hC8);
		wr(A_C1, 8'h0D);
		u_src.send_pulses(5);
		rd(A_D1, 8'h05, RESP_OKAY, 1'b0);
		wr(A_C1, 8'h0F);
		u_src.send_pulses(3);
		rd(A_D1, 8'h05, RESP_OKAY, 1'b0);
		wr(A_C1, 8'h0D);
		u_src.send_pulses(2);
		rd(A_D1, 8'h07, RESP_OKAY, 1'b0);
		wr(A_C1, 8'h0E);
		wr(A_C1, 8'h0D);
		rd(A_D1, 8'h00, RESP_OKAY, 1'b0);
		wr(A_C1, 8'h0C);
		wr(A_C1, 8'h0D);
		u_src.send_pulses(1);
		rd(A_D1, 8'h01, RESP_OKAY, 1'b0);
		// random compare value: match after n plus one counts
		rnd = lfsr(rnd);
		n = {4'h0, rnd[3:0]} + 8'h01;
		wr(A_C1, 8'h4C);
		wr(A_D1, n);
		wr(A_C1, 8'h4D);
		u_src.send_pulses(int'(n) + 1);
		rd(A_D1, 8'h00, RESP_OKAY, 1'b0);
		rd(A_C1, 8'hCD, RESP_OKAY, 1'b0);
		out_is(2, 1'b1);
		wr(A_C1, 8'hCD);
		out_is(2, 1'b1);
		wr(A_C1, 8'h4D);
		out_is(2, 1'b0);
		rd(A_C1, 8'h4D, RESP_OKAY, 1'b0);
		rd(A_C1, 8'hCD, RESP_OKAY, 1'b1);
		wr(A_C1, 8'h0D);
		u_src.send_pulses(int'(n) + 1);
		out_is(2, 1'b0);
		rd(A_C1, 8'h8D, RESP_OKAY, 1'b0);
		wr(A_C1, 8'h00);
		$display("test external done");
		repeat (4) @(posedge clk_i);
		tally_and_finish();
	end
endmodule : tb
